/* File: pkg/ssm_pkg.sv */
// How it works
// RULE1: literal pair form: signed base times literal
// RULE2: literal is five unsigned instruction k bits
// RULE3: base and pair product signed, literal unsigned
// RULE4: register form: source operand taken unsigned
// RULE5: low word to even d, high next
// RULE6: software picks even W0..W12, never W14
// RULE7: base and destination are register direct only
// RULE8: source direct or indirect with pointer update
// RULE9: p bits give mode, s bits register
// RULE10: word width only, no byte variant
// RULE11: pair forms ignore fraction and sign mode
// RULE12: accumulator load sign-extended through bit 39
// RULE13: A bit picks accumulator a or b
// RULE14: accumulator forms honour fraction select bit
// RULE15: accumulator forms: first signed, second unsigned
// RULE16: accumulator forms ignore sign mode field
// RULE17: accumulator form decoded by opcode pattern
// RULE18: accumulator literal taken from k bits
// RULE19: slow operand reads may add cycles
// RULE20: flags untouched, one word, one issue slot
// RULE21: byte multiply uses working register zero; this block refuses byte multiplies instead
package ssm_pkg;
    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 16;
    localparam logic [7:0] OPC_SU = 8'hB9;
    localparam logic [7:0] OPC_BYTE_MUL = 8'hBC;
    localparam int BYTE_BIT = 14;
    localparam int FORM_BIT = 15;
    localparam int BASE_HI = 14;
    localparam int BASE_LO = 11;
    localparam int DST_HI = 10;
    localparam int DST_LO = 7;
    localparam int ACC_MARK_HI = 10;
    localparam int ACC_MARK_LO = 8;
    localparam logic [2:0] ACC_MARK = 3'h7;
    localparam int ACC_SEL_BIT = 7;
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 4;
    localparam int LIT_MARK_HI = 6;
    localparam int LIT_MARK_LO = 5;
    localparam logic [1:0] LIT_MARK = 2'h3;
    localparam int SRC_HI = 3;
    localparam int SRC_LO = 0;
    localparam int LIT_HI = 4;
    localparam int LIT_LO = 0;

    // ------------------------------------------------------------
    // widths, steps and reset values
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ACC_W = 40;
    localparam int LIT_W = 5;
    localparam logic [15:0] PTR_STEP = 16'h0002;
    localparam logic [3:0] DEFAULT_WORKING_REG = 4'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [39:0] RST_ACC = 40'h00_0000_0000;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam int PIPE_LATENCY = 3;

    // source addressing modes, in encoding order of the p field
    typedef enum logic [2:0] {
        SSM_DIRECT,
        SSM_IND,
        SSM_POSTINC,
        SSM_POSTDEC,
        SSM_PREINC,
        SSM_PREDEC
    } ssm_mode_type;
endpackage

/* File: logic/ssm_mult16.sv */
`timescale 1ns/100ps
module ssm_mult16
    import ssm_pkg::*;
(
    // operands
    input wire logic [15:0] base_val,
    input wire logic [15:0] opnd_val,
    input wire logic frac_mode,
    // product
    output logic [31:0] prod_word,
    output logic [39:0] prod_acc
);
    // ------------------------------------------------------------
    // signed by unsigned core
    // ------------------------------------------------------------
    logic signed [32:0] raw_prod;
    logic signed [33:0] frac_prod;

    // zero-extend the second operand so it can never read as negative
    assign raw_prod = $signed({base_val[15], base_val}) * $signed({1'b0, opnd_val}); // RULE3 RULE4 RULE15
    // fractional mode is a one-place left shift of the integer product
    assign frac_prod = frac_mode ? {raw_prod, 1'b0} : {raw_prod[32], raw_prod}; // RULE14
    // a 17x17 product of these ranges always fits 32 bits signed
    assign prod_word = raw_prod[31:0]; // RULE1
    // sign-extend whatever sits at the top up to the accumulator width
    assign prod_acc = {{6{frac_prod[33]}}, frac_prod}; // RULE12
endmodule

/* File: logic/ssm_top.sv */
`timescale 1ns/100ps
module ssm_top
    import ssm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // issue from decode
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic mem_wait,
    // core control bits
    input wire logic core_if_frac,
    input wire logic [1:0] multiplier_sign_mode,
    // working register file reads
    output logic [3:0] base_reg_sel_ff,
    output logic [3:0] src_reg_sel_ff,
    input wire logic [15:0] base_rdata,
    input wire logic [15:0] src_rdata,
    // indirect operand fetch
    output logic mem_rd_ff,
    output logic [15:0] mem_addr_ff,
    input wire logic [15:0] mem_rdata,
    // pointer update
    output logic ptr_we_ff,
    output logic [3:0] ptr_reg_ff,
    output logic [15:0] ptr_data_ff,
    // register pair write
    output logic pair_we_ff,
    output logic [3:0] pair_addr_ff,
    output logic [15:0] pair_lo_ff,
    output logic [15:0] pair_hi_ff,
    // accumulator write
    output logic acc_we_ff,
    output logic acc_sel_b_ff,
    output logic [39:0] acc_data_ff,
    // decode refusal
    output logic unsupported_ff
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_su_op(input logic [23:0] w);
        is_su_op = (w[OPC_HI:OPC_LO] == OPC_SU) && !w[FORM_BIT];
    endfunction

    function automatic logic is_acc_form(input logic [23:0] w);
        is_acc_form = w[ACC_MARK_HI:ACC_MARK_LO] == ACC_MARK; // RULE17
    endfunction

    function automatic logic is_lit_form(input logic [23:0] w);
        is_lit_form = w[LIT_MARK_HI:LIT_MARK_LO] == LIT_MARK;
    endfunction

    // the whole pipe freezes while a slow operand read is outstanding
    logic stall;
    logic take;
    assign stall = mem_wait; // RULE19
    assign take = instr_valid && !stall;

    // ------------------------------------------------------------
    // decode stage
    // ------------------------------------------------------------
    logic d_valid_ff;
    logic d_acc_ff;
    logic d_lit_ff;
    logic d_accumulator_b_ff;
    logic [3:0] d_dst_ff;
    logic [4:0] d_short_literal_ff;
    ssm_mode_type d_mode_ff;
    logic [23:0] w;
    assign w = instr_word;

    // latch fields; the k bits only matter for literal forms
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d_valid_ff <= 1'b0;
            d_acc_ff <= 1'b0;
            d_lit_ff <= 1'b0;
            d_accumulator_b_ff <= 1'b0;
            d_dst_ff <= RST_SEL;
            d_short_literal_ff <= '0;
            d_mode_ff <= SSM_DIRECT;
            base_reg_sel_ff <= RST_SEL;
            src_reg_sel_ff <= RST_SEL;
        end else if (!stall) begin
            d_valid_ff <= take && is_su_op(w);
            d_acc_ff <= is_acc_form(w); // RULE17
            d_lit_ff <= is_lit_form(w);
            d_accumulator_b_ff <= w[ACC_SEL_BIT]; // RULE13
            d_dst_ff <= w[DST_HI:DST_LO]; // RULE5 RULE7
            d_short_literal_ff <= w[LIT_HI:LIT_LO]; // RULE2 RULE18
            // codes 6 and 7 are the literal marker, never a mode
            d_mode_ff <= is_lit_form(w) ? SSM_DIRECT : ssm_mode_type'(w[MODE_HI:MODE_LO]); // RULE9
            base_reg_sel_ff <= w[BASE_HI:BASE_LO]; // RULE7
            src_reg_sel_ff <= w[SRC_HI:SRC_LO]; // RULE9
        end
    end

    // byte multiplies (which use the default working register) and
    // anything else are refused with a one-cycle pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unsupported_ff <= 1'b0;
        end else begin
            unsupported_ff <= take && !is_su_op(w); // RULE10 RULE21
        end
    end

    // ------------------------------------------------------------
    // operand stage
    // ------------------------------------------------------------
    logic a_valid_ff;
    logic a_acc_ff;
    logic a_accumulator_b_ff;
    logic a_from_mem_ff;
    logic [3:0] a_dst_ff;
    logic [15:0] a_base_ff;
    logic [15:0] a_opnd_ff;
    logic [15:0] nxt_addr;
    logic [15:0] nxt_ptr;
    logic nxt_ptr_we;
    logic nxt_indirect;

    // effective address and pointer side effect for the source
    always_comb begin
        nxt_addr = src_rdata;
        nxt_ptr = src_rdata;
        nxt_ptr_we = 1'b0;
        nxt_indirect = 1'b1;
        case (d_mode_ff)
            SSM_DIRECT: begin
                nxt_indirect = 1'b0;
            end
            SSM_IND: begin
                nxt_addr = src_rdata;
            end
            SSM_POSTINC: begin
                nxt_ptr = src_rdata + PTR_STEP; // RULE8
                nxt_ptr_we = 1'b1;
            end
            SSM_POSTDEC: begin
                nxt_ptr = src_rdata - PTR_STEP; // RULE8
                nxt_ptr_we = 1'b1;
            end
            SSM_PREINC: begin
                nxt_addr = src_rdata + PTR_STEP; // RULE8
                nxt_ptr = nxt_addr;
                nxt_ptr_we = 1'b1;
            end
            SSM_PREDEC: begin
                nxt_addr = src_rdata - PTR_STEP; // RULE8
                nxt_ptr = nxt_addr;
                nxt_ptr_we = 1'b1;
            end
            default: begin
                nxt_indirect = 1'b0;
            end
        endcase
    end

    // capture operands; literal zero-extends so it reads unsigned
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_valid_ff <= 1'b0;
            a_acc_ff <= 1'b0;
            a_accumulator_b_ff <= 1'b0;
            a_from_mem_ff <= 1'b0;
            a_dst_ff <= RST_SEL;
            a_base_ff <= RST_WORD;
            a_opnd_ff <= RST_WORD;
        end else if (!stall) begin
            a_valid_ff <= d_valid_ff;
            a_acc_ff <= d_acc_ff;
            a_accumulator_b_ff <= d_accumulator_b_ff;
            a_from_mem_ff <= d_valid_ff && !d_lit_ff && nxt_indirect;
            a_dst_ff <= d_dst_ff;
            a_base_ff <= base_rdata; // RULE7
            a_opnd_ff <= d_lit_ff ? {11'h000, d_short_literal_ff} : src_rdata; // RULE2 RULE3
        end
    end

    // memory read is set on each advance and held through a stall; pointer write pulses once per advance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= RST_WORD;
            ptr_we_ff <= 1'b0;
            ptr_reg_ff <= RST_SEL;
            ptr_data_ff <= RST_WORD;
        end else if (stall) begin
            ptr_we_ff <= 1'b0;
        end else begin
            mem_rd_ff <= d_valid_ff && !d_lit_ff && nxt_indirect; // RULE8
            mem_addr_ff <= nxt_addr;
            ptr_we_ff <= d_valid_ff && !d_lit_ff && nxt_ptr_we; // RULE8
            ptr_reg_ff <= src_reg_sel_ff;
            ptr_data_ff <= nxt_ptr;
        end
    end

    // ------------------------------------------------------------
    // execute stage
    // ------------------------------------------------------------
    logic [15:0] e_opnd;
    logic [31:0] prod_word;
    logic [39:0] prod_acc;
    assign e_opnd = a_from_mem_ff ? mem_rdata : a_opnd_ff;

    // fraction select only reaches accumulator forms; the sign mode
    // field is never read by this block
    ssm_mult16 u_mult (
        .base_val(a_base_ff),
        .opnd_val(e_opnd),
        .frac_mode(a_acc_ff && core_if_frac), // RULE11 RULE14 RULE16
        .prod_word(prod_word),
        .prod_acc(prod_acc)
    );

    // results; status flags are not driven at all, so they stay put
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pair_we_ff <= 1'b0;
            pair_addr_ff <= RST_SEL;
            pair_lo_ff <= RST_WORD;
            pair_hi_ff <= RST_WORD;
            acc_we_ff <= 1'b0;
            acc_sel_b_ff <= 1'b0;
            acc_data_ff <= RST_ACC;
        end else if (stall) begin
            pair_we_ff <= 1'b0;
            acc_we_ff <= 1'b0;
        end else begin
            pair_we_ff <= a_valid_ff && !a_acc_ff; // RULE20
            pair_addr_ff <= a_dst_ff; // RULE5
            pair_lo_ff <= prod_word[15:0]; // RULE5
            pair_hi_ff <= prod_word[31:16]; // RULE5
            acc_we_ff <= a_valid_ff && a_acc_ff;
            acc_sel_b_ff <= a_accumulator_b_ff; // RULE13
            acc_data_ff <= prod_acc; // RULE12
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic signed [32:0] chk_prod;
    assign chk_prod = $signed({a_base_ff[15], a_base_ff}) * $signed({1'b0, e_opnd});

    pair_latency_a: assert property ( // RULE20
        take && is_su_op(w) && !is_acc_form(w) ##1 !mem_wait [*2] |-> ##1 pair_we_ff)
        else $error("pair write missing three cycles after issue");

    acc_select_a: assert property ( // RULE13
        take && is_su_op(w) && is_acc_form(w) && w[ACC_SEL_BIT] ##1 !mem_wait [*2] |=> acc_we_ff && acc_sel_b_ff)
        else $error("accumulator b not chosen");

    pair_dest_a: assert property ( // RULE5
        take && is_su_op(w) && !is_acc_form(w) ##1 !mem_wait [*2] |=> pair_addr_ff == $past(w[DST_HI:DST_LO], 3))
        else $error("pair destination wrong");

    pair_value_a: assert property ( // RULE3
        pair_we_ff |-> {pair_hi_ff, pair_lo_ff} == $past(chk_prod[31:0]))
        else $error("pair product wrong");

    acc_sign_ext_a: assert property ( // RULE12
        acc_we_ff |-> acc_data_ff[39:33] == {7{acc_data_ff[32]}})
        else $error("accumulator not sign-extended");

    frac_shift_a: assert property ( // RULE14
        acc_we_ff && $past(core_if_frac) |-> !acc_data_ff[0] && acc_data_ff[32:1] == $past(chk_prod[31:0]))
        else $error("fractional product not shifted");

    lit_unsigned_a: assert property ( // RULE2
        d_valid_ff && d_lit_ff && !stall |=> a_opnd_ff == {11'h000, $past(d_short_literal_ff)})
        else $error("literal not zero-extended");

    ptr_step_a: assert property ( // RULE8
        ptr_we_ff |-> (ptr_data_ff == $past(src_rdata) + PTR_STEP) || (ptr_data_ff == $past(src_rdata) - PTR_STEP))
        else $error("pointer step not one word");

    refuse_byte_a: assert property ( // RULE10
        take && w[OPC_HI:OPC_LO] == OPC_BYTE_MUL |=> unsupported_ff && !d_valid_ff)
        else $error("byte multiply accepted");

    stall_hold_a: assert property ( // RULE19
        mem_wait |=> !pair_we_ff && !acc_we_ff && !ptr_we_ff)
        else $error("write during stall");

    acc_a_select_a: assert property ( // RULE13
        take && is_su_op(w) && is_acc_form(w) && !w[ACC_SEL_BIT] ##1 !mem_wait [*2] |=> acc_we_ff && !acc_sel_b_ff)
        else $error("accumulator a not chosen");

    acc_int_value_a: assert property ( // RULE12
        acc_we_ff && !$past(core_if_frac) |-> acc_data_ff == {{8{$past(chk_prod[31])}}, $past(chk_prod[31:0])})
        else $error("integer accumulator value wrong");

    one_dest_a: assert property ( // RULE17
        !(pair_we_ff && acc_we_ff))
        else $error("pair and accumulator written together");

    refuse_other_a: assert property ( // RULE17
        take && !is_su_op(w) |=> unsupported_ff && !d_valid_ff)
        else $error("foreign opcode accepted");

    // operand path checks
    base_direct_a: assert property ( // RULE7
        take |=> base_reg_sel_ff == $past(w[BASE_HI:BASE_LO]))
        else $error("base register select wrong");

    src_select_a: assert property ( // RULE9
        take |=> src_reg_sel_ff == $past(w[SRC_HI:SRC_LO]))
        else $error("source register select wrong");

    lit_no_fetch_a: assert property ( // RULE18
        d_valid_ff && d_lit_ff && !stall |=> !mem_rd_ff && !ptr_we_ff)
        else $error("literal form touched memory");

    direct_opnd_a: assert property ( // RULE8
        d_valid_ff && !d_lit_ff && d_mode_ff == SSM_DIRECT && !stall |=> !mem_rd_ff && a_opnd_ff == $past(src_rdata))
        else $error("direct source operand wrong");

    preinc_addr_a: assert property ( // RULE8
        d_valid_ff && !d_lit_ff && d_mode_ff == SSM_PREINC && !stall |=>
        mem_rd_ff && mem_addr_ff == $past(src_rdata) + PTR_STEP)
        else $error("pre-increment address wrong");

    postdec_ptr_a: assert property ( // RULE8
        d_valid_ff && !d_lit_ff && d_mode_ff == SSM_POSTDEC && !stall |=>
        ptr_we_ff && mem_addr_ff == $past(src_rdata) && ptr_data_ff == $past(src_rdata) - PTR_STEP)
        else $error("post-decrement pointer wrong");

    ptr_reg_a: assert property ( // RULE9
        d_valid_ff && !d_lit_ff && !stall |=> ptr_reg_ff == $past(src_reg_sel_ff))
        else $error("pointer register wrong");

    // main scenarios
    cover_pair_c: cover property (pair_we_ff && pair_hi_ff[15]);
    cover_acc_b_c: cover property (acc_we_ff && acc_sel_b_ff);
    cover_acc_frac_c: cover property (acc_we_ff && $past(core_if_frac));
    cover_preinc_c: cover property (ptr_we_ff && mem_rd_ff && mem_addr_ff == ptr_data_ff);
    cover_stall_c: cover property (mem_wait [*2] ##1 !mem_wait ##1 pair_we_ff);
endmodule

/* File: tb/ssm_regfile_model.sv */
`timescale 1ns/100ps
module ssm_regfile_model (
    // clock
    input wire logic clk,
    // register reads
    input wire logic [3:0] base_sel,
    input wire logic [3:0] src_sel,
    output logic [15:0] base_rdata,
    output logic [15:0] src_rdata,
    // operand memory
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [15:0] mem_rdata,
    // write-back
    input wire logic ptr_we,
    input wire logic [3:0] ptr_reg,
    input wire logic [15:0] ptr_data,
    input wire logic pair_we,
    input wire logic [3:0] pair_addr,
    input wire logic [15:0] pair_lo,
    input wire logic [15:0] pair_hi
);
    logic [15:0] regs [16];
    logic [15:0] junk = 16'h0000;

    // reads are combinational, in the same cycle as the select
    assign base_rdata = regs[base_sel];
    assign src_rdata = regs[src_sel];
    // data follows the address; outside a read the bus churns so stale data is never trusted
    assign mem_rdata = mem_rd ? (mem_addr ^ 16'h5A5A) : junk;

    // pointer and pair writes land on the edge that samples their strobes
    always @(posedge clk) begin
        junk <= ~junk;
        if (ptr_we) begin
            regs[ptr_reg] <= ptr_data;
        end
        if (pair_we) begin
            regs[pair_addr] <= pair_lo;
            regs[pair_addr + 4'h1] <= pair_hi;
        end
    end
endmodule

/* File: tb/ssm_top_tb.sv */
`timescale 1ns/100ps
module ssm_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic iv = 1'b0;
    logic mw = 1'b0;
    logic frac = 1'b0;
    logic [23:0] iw = 24'h000000;
    logic [1:0] usm = 2'h0;
    logic [3:0] bsel, ssel, preg, paddr;
    logic [15:0] brd, srd, maddr, mdat, pdat, plo, phi, ea, np;
    logic mrd, pwe, we2, awe, asel, unsup;
    logic [39:0] adat;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    ssm_top i_ssm_top (.clk(clk), .nrst(nrst), .instr_valid(iv), .instr_word(iw), .mem_wait(mw),
        .core_if_frac(frac), .multiplier_sign_mode(usm), .base_reg_sel_ff(bsel), .src_reg_sel_ff(ssel),
        .base_rdata(brd), .src_rdata(srd), .mem_rd_ff(mrd), .mem_addr_ff(maddr), .mem_rdata(mdat),
        .ptr_we_ff(pwe), .ptr_reg_ff(preg), .ptr_data_ff(pdat), .pair_we_ff(we2), .pair_addr_ff(paddr),
        .pair_lo_ff(plo), .pair_hi_ff(phi), .acc_we_ff(awe), .acc_sel_b_ff(asel), .acc_data_ff(adat),
        .unsupported_ff(unsup));

    ssm_regfile_model i_ssm_regfile_model (.clk(clk), .base_sel(bsel), .src_sel(ssel), .base_rdata(brd),
        .src_rdata(srd), .mem_rd(mrd), .mem_addr(maddr), .mem_rdata(mdat), .ptr_we(pwe), .ptr_reg(preg),
        .ptr_data(pdat), .pair_we(we2), .pair_addr(paddr), .pair_lo(plo), .pair_hi(phi));

    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_a(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // a hang is cut short well beyond the hundred-odd cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------
    // expected values and instruction words
    // ----------------------------------------
    function automatic logic [39:0] prod(input logic [15:0] b, input logic [15:0] o, input logic sh);
        logic signed [39:0] p;
        p = $signed({{24{b[15]}}, b}) * $signed({24'h000000, o});
        return sh ? (p <<< 1) : p;
    endfunction

    function automatic logic [23:0] enc(input logic [3:0] b, input logic [3:0] d, input logic [6:0] lo);
        return {8'hB9, 1'b0, b, d, lo};
    endfunction

    task automatic put_reg(input int n, input logic [15:0] v);
        i_ssm_regfile_model.regs[n] = v;
    endtask

    // one issue cycle; inputs move 1 ns after the edge
    task automatic issue(input logic [23:0] w);
        @(posedge clk);
        #1;
        iv = 1'b1;
        iw = w;
        @(posedge clk);
        #1;
        iv = 1'b0;
    endtask

    // issue, stall the pipe for a number of cycles, then check the write-back
    task automatic exec(input logic [23:0] w, input int stall, input logic acc, input logic [3:0] sel,
        input logic [39:0] v);
        int lat;
        lat = 0;
        issue(w);
        while (we2 !== 1'b1 && awe !== 1'b1 && lat < 12) begin
            mw = (lat >= 1 && lat <= stall);
            @(posedge clk);
            #1;
            lat++;
        end
        mw = 1'b0;
        // lat counts edges after the take edge, the issue cycle itself adds one
        chk_w(16'(lat + 1), 16'(ssm_pkg::PIPE_LATENCY + stall));
        chk_w({14'h0, we2, awe}, acc ? 16'h0001 : 16'h0002);
        if (acc) begin
            chk_w({15'h0, asel}, {15'h0, sel[0]});
            chk_a(adat, v);
        end else begin
            chk_w({12'h0, paddr}, {12'h0, sel});
            chk_w(plo, v[15:0]);
            chk_w(phi, v[31:16]);
        end
        // let the write-back land before the caller touches the register file
        @(posedge clk);
        #1;
    endtask

    // a refused word pulses the refusal flag once and writes nothing
    task automatic refuse(input logic [23:0] w);
        issue(w);
        // the refusal pulse stands in the cycle right after the take edge
        chk_w({15'h0, unsup}, 16'h0001);
        repeat (3) begin
            @(posedge clk);
            #1;
            chk_w({14'h0, we2, awe}, 16'h0000);
        end
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk_w({14'h0, we2, unsup}, 16'h0000);
        nrst = 1'b1;
        // sign mode and fraction select must not touch the pair forms
        for (int i = 0; i < 4; i++) begin
            usm = 2'(i);
            frac = i[0];
            put_reg(0, 16'hC000);
            exec(enc(4'h0, 4'h2, 7'h7F), 0, 1'b0, 4'h2, prod(16'hC000, 16'h001F, 1'b0));
        end
        put_reg(2, 16'hF240);
        exec(enc(4'h2, 4'h0, 7'h70), 0, 1'b0, 4'h0, prod(16'hF240, 16'h0010, 1'b0));
        exec(enc(4'h2, 4'hC, 7'h60), 0, 1'b0, 4'hC, 40'h0);
        $display("test literal pair done");
        put_reg(8, 16'hF000);
        put_reg(9, 16'hF000);
        exec(enc(4'h8, 4'h0, 7'h09), 0, 1'b0, 4'h0, prod(16'hF000, 16'hF000, 1'b0));
        $display("test register pair done");
        // every indirect mode, each but plain indirect with its own pointer update
        for (int p = 1; p < 6; p++) begin
            put_reg(3, 16'h0280);
            put_reg(2, 16'h0040);
            ea = (p == 4) ? 16'h0282 : ((p == 5) ? 16'h027E : 16'h0280);
            np = (p == 2 || p == 4) ? 16'h0282 : ((p == 3 || p == 5) ? 16'h027E : 16'h0280);
            exec(enc(4'h2, 4'h4, {3'(p), 4'h3}), 0, 1'b0, 4'h4, prod(16'h0040, ea ^ 16'h5A5A, 1'b0));
            chk_w(i_ssm_regfile_model.regs[3], np);
        end
        $display("test indirect done");
        for (int i = 0; i < 4; i++) begin
            usm = 2'(3 - i);
            frac = i[1];
            put_reg(8, 16'hF000);
            exec(enc(4'h8, {3'h7, i[0]}, 7'h09), 0, 1'b1, {3'h0, i[0]}, prod(16'hF000, 16'hF000, i[1]));
            put_reg(8, 16'h0042);
            exec(enc(4'h8, {3'h7, i[0]}, 7'h62), 0, 1'b1, {3'h0, i[0]}, prod(16'h0042, 16'h0002, i[1]));
        end
        $display("test accumulator done");
        // a stalled indirect read still updates its pointer once
        put_reg(3, 16'h0280);
        exec(enc(4'h2, 4'h4, 7'h23), 3, 1'b0, 4'h4, prod(16'h0040, 16'h0280 ^ 16'h5A5A, 1'b0));
        chk_w(i_ssm_regfile_model.regs[3], 16'h0282);
        $display("test stall done");
        // back to back issue, one write-back per cycle
        put_reg(0, 16'h0003);
        put_reg(1, 16'h0005);
        @(posedge clk);
        #1;
        iv = 1'b1;
        iw = enc(4'h0, 4'h2, 7'h61);
        @(posedge clk);
        #1;
        iw = enc(4'h1, 4'h6, 7'h62);
        @(posedge clk);
        #1;
        iv = 1'b0;
        @(posedge clk);
        #1;
        chk_a({19'h0, we2, paddr, plo}, {19'h0, 1'b1, 4'h2, 16'h0003});
        @(posedge clk);
        #1;
        chk_a({19'h0, we2, paddr, plo}, {19'h0, 1'b1, 4'h6, 16'h000A});
        $display("test back to back done");
        refuse(24'hBC4000);
        refuse(24'hB98000);
        $display("test refusal done");
        final_report();
    end
endmodule
